// [hdl/port_mode_pkg.sv]
/*
 * Constants and carrier types for the port pin mode control block.
 * Assumes a 32-bit AXI4-Lite register bus and five 8-bit ports.
 */
package port_mode_pkg;

    localparam int unsigned NUM_PORTS = 5;
    localparam int unsigned PORT_W    = 8;

    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_P3_MODE_A   = 8'h9E;
    localparam logic [7:0] IDX_P0_MODE_A   = 8'hB1;
    localparam logic [7:0] IDX_P0_MODE_B   = 8'hB2;
    localparam logic [7:0] IDX_P1_MODE_A   = 8'hB3;
    localparam logic [7:0] IDX_P1_MODE_B   = 8'hB4;
    localparam logic [7:0] IDX_P2_MODE_A   = 8'hB5;
    localparam logic [7:0] IDX_P2_MODE_B   = 8'hB6;
    localparam logic [7:0] IDX_THRESH_SEL  = 8'hEC;
    localparam logic [7:0] IDX_P4_MODE_A   = 8'hFA;
    localparam logic [7:0] IDX_P4_MODE_B   = 8'hFB;
    // Registers without a printed offset
    localparam logic [7:0] IDX_P3_MODE_B   = 8'hC0;
    localparam logic [7:0] IDX_PORT_LATCH0 = 8'hC1;

    localparam int unsigned ADDR_W = 12;

    // Implemented-bit masks
    localparam logic [7:0] MASK_FULL   = 8'hFF;
    localparam logic [7:0] MASK_PORT1  = 8'h8F;
    localparam logic [7:0] MASK_PORT4  = 8'h0F;
    localparam logic [7:0] MASK_THRESH = 8'h1F;

    localparam logic [7:0] RST_MODE   = 8'h00;
    localparam logic [7:0] RST_THRESH = 8'h00;

    // Dedicated input pin and serial-bus pins on port 1
    localparam int unsigned DED_IN_PORT = 1;
    localparam int unsigned DED_IN_BIT  = 4;
    localparam int unsigned SDA_BIT     = 5;
    localparam int unsigned SCL_BIT     = 6;

    // Strong pull-up pulse length
    localparam int unsigned STRONG_PU_CLKS = 2;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_QUASI,
        MODE_PUSH_PULL,
        MODE_INPUT_ONLY,
        MODE_OPEN_DRAIN
    } pin_mode_t;

    // Driver enables for one pin
    typedef struct packed {
        logic very_weak_pu;
        logic weak_pu;
        logic strong_pu;
        logic pull_down;
        logic schmitt;
    } pin_drive_t;

endpackage

// [hdl/port_pin_mode_control.sv]
/*
 * Port pin mode control: mode registers, threshold select and per-pin
 * driver enables for five 8-bit ports behind an AXI4-Lite slave.
 * Assumes the port latches come from the CPU core and the pin levels are
 * already synchronous to clk_i; pads turn the enables into pin drive.
 */
// Our own choice: the AXI4-Lite register port.
// Notes on behaviour
// RL1 - Quasi mode: very weak pull-up when latch 1
// RL2 - Quasi mode: weak pull-up when latch and pin 1
// RL3 - Quasi mode: strong pull-up two clocks on rise
// RL4 - Quasi mode: latch 0 drives pin low
// RL5 - Open drain: no pull-ups, pull-down on latch 0
// RL6 - Push-pull: strong pull-up while latch holds 1
// RL7 - Input only: all drivers off
// RL8 - Dedicated input pin has no output mode
// RL9 - Reset level from config bit, weak high
// RL10 - Quasi mode is the reset default
// RL11 - Per-port bit selects Schmitt or TTL
// RL12 - Dedicated input pin always Schmitt
// RL13 - Port 1 mode bits only 7, 3..0
// RL14 - Port 4 mode bits only 3..0
// RL15 - Mode bits decode: 00 quasi, 01 pp, 10 in, 11 od
// RL16 - Serial-bus pins always open drain
// RL17 - Unimplemented bits read zero, writes ignored
// RL18 - Mode write takes effect next cycle
`timescale 1ns/1ns
`default_nettype none

module port_pin_mode_control #(
    parameter int unsigned STRONG_CLKS = port_mode_pkg::STRONG_PU_CLKS
) (
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   reset_level_select_i,
    input  wire logic [39:0]            latch_i,
    input  wire logic [39:0]            pin_level_i,
    output logic      [39:0]            latch_o,
    output port_mode_pkg::pin_drive_t   drive_o [40],
    input  wire logic [11:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic      [1:0]             s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [11:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic      [31:0]            s_axi_rdata,
    output logic      [1:0]             s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);

    logic [7:0]  mode_a_q [5];
    logic [7:0]  mode_b_q [5];
    logic [7:0]  thresh_q;
    logic [39:0] prev_latch_q;
    logic [39:0] latch_rst_q;
    logic        rst_seen_q;

    // Write path holds address and data until both have arrived
    logic [11:0] aw_q;
    logic        aw_full_q;
    logic [31:0] w_q;
    logic [3:0]  ws_q;
    logic        w_full_q;

    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_q && !s_axi_bvalid;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            aw_full_q <= 1'b0;
            aw_q      <= 12'h000;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_full_q <= 1'b1;
            aw_q      <= s_axi_awaddr;
        end
        else if (aw_full_q && w_full_q)
        begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            w_full_q <= 1'b0;
            w_q      <= 32'h0000_0000;
            ws_q     <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_full_q <= 1'b1;
            w_q      <= s_axi_wdata;
            ws_q     <= s_axi_wstrb;
        end
        else if (aw_full_q && w_full_q)
        begin
            w_full_q <= 1'b0;
        end
    end

    logic       wr_go;
    logic [7:0] wr_idx;
    logic       wr_lo;
    logic [7:0] wbyte;
    logic       wr_hit;
    logic       wr_en;

    assign wr_go  = aw_full_q && w_full_q;
    assign wr_idx = aw_q[9:2];
    assign wr_lo  = ws_q[0];
    assign wbyte  = w_q[7:0];

    function automatic logic map_hit(input logic [7:0] idx);
        map_hit = (idx == port_mode_pkg::IDX_P0_MODE_A) ||
                  (idx == port_mode_pkg::IDX_P0_MODE_B) ||
                  (idx == port_mode_pkg::IDX_P1_MODE_A) ||
                  (idx == port_mode_pkg::IDX_P1_MODE_B) ||
                  (idx == port_mode_pkg::IDX_P2_MODE_A) ||
                  (idx == port_mode_pkg::IDX_P2_MODE_B) ||
                  (idx == port_mode_pkg::IDX_P3_MODE_A) ||
                  (idx == port_mode_pkg::IDX_P3_MODE_B) ||
                  (idx == port_mode_pkg::IDX_P4_MODE_A) ||
                  (idx == port_mode_pkg::IDX_P4_MODE_B) ||
                  (idx == port_mode_pkg::IDX_THRESH_SEL);
    endfunction

    assign wr_hit = map_hit(wr_idx) && (aw_q[11:10] == 2'h0)
                    && (aw_q[1:0] == 2'h0);
    // Misaddressed writes get an error answer and change nothing
    assign wr_en  = wr_go && wr_lo && wr_hit;

    localparam logic [7:0] IDX_A [5] = '{port_mode_pkg::IDX_P0_MODE_A,
        port_mode_pkg::IDX_P1_MODE_A, port_mode_pkg::IDX_P2_MODE_A,
        port_mode_pkg::IDX_P3_MODE_A, port_mode_pkg::IDX_P4_MODE_A};
    localparam logic [7:0] IDX_B [5] = '{port_mode_pkg::IDX_P0_MODE_B,
        port_mode_pkg::IDX_P1_MODE_B, port_mode_pkg::IDX_P2_MODE_B,
        port_mode_pkg::IDX_P3_MODE_B, port_mode_pkg::IDX_P4_MODE_B};
    // RL13 RL14 implemented masks
    localparam logic [7:0] MASK [5] = '{port_mode_pkg::MASK_FULL,
        port_mode_pkg::MASK_PORT1, port_mode_pkg::MASK_FULL,
        port_mode_pkg::MASK_FULL, port_mode_pkg::MASK_PORT4};

    genvar gp;
    generate
        for (gp = 0; gp < 5; gp++)
        begin : g_port
            // RL17 RL18 masked write, used next cycle
            always_ff @(posedge clk_i)
            begin
                if (sys_rst_i)
                begin
                    mode_a_q[gp] <= port_mode_pkg::RST_MODE;
                    mode_b_q[gp] <= port_mode_pkg::RST_MODE;
                end
                else if (wr_en && wr_idx == IDX_A[gp])
                begin
                    mode_a_q[gp] <= wbyte & MASK[gp];
                end
                else if (wr_en && wr_idx == IDX_B[gp])
                begin
                    mode_b_q[gp] <= wbyte & MASK[gp];
                end
            end
        end
    endgenerate

    // RL11 RL17 threshold select bits
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            thresh_q <= port_mode_pkg::RST_THRESH;
        end
        else if (wr_en && wr_idx == port_mode_pkg::IDX_THRESH_SEL)
        begin
            thresh_q <= wbyte & port_mode_pkg::MASK_THRESH;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= port_mode_pkg::AXI_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? port_mode_pkg::AXI_OKAY
                                   : port_mode_pkg::AXI_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read path: one-cycle answer
    logic [7:0] rd_idx;
    logic [7:0] rd_byte;
    logic       rd_ok;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx        = s_axi_araddr[9:2];
    assign rd_ok         = map_hit(rd_idx) && (s_axi_araddr[11:10] == 2'h0)
                           && (s_axi_araddr[1:0] == 2'h0);

    always_comb
    begin
        rd_byte = 8'h00;
        for (int i = 0; i < 5; i++)
        begin
            if (rd_idx == IDX_A[i])
            begin
                rd_byte = mode_a_q[i];
            end
            if (rd_idx == IDX_B[i])
            begin
                rd_byte = mode_b_q[i];
            end
        end
        if (rd_idx == port_mode_pkg::IDX_THRESH_SEL)
        begin
            rd_byte = thresh_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= port_mode_pkg::AXI_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            s_axi_rresp  <= rd_ok ? port_mode_pkg::AXI_OKAY
                                  : port_mode_pkg::AXI_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // RL9 latches start at the configured level, held through reset
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rst_seen_q  <= 1'b1;
            latch_rst_q <= {40{reset_level_select_i}};
        end
        else if (rst_seen_q && latch_i != latch_rst_q)
        begin
            rst_seen_q <= 1'b0;
        end
    end

    assign latch_o = rst_seen_q ? latch_rst_q : latch_i;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            // Match latch_o so leaving reset shows no false rise
            prev_latch_q <= {40{reset_level_select_i}};
        end
        else
        begin
            prev_latch_q <= latch_o;
        end
    end

    // Strong pull-up counters, one per pin
    logic [1:0] spu_cnt_q [40];

    genvar gb;
    generate
        for (gb = 0; gb < 40; gb++)
        begin : g_pin
            localparam int P = gb / 8;
            localparam int B = gb % 8;
            localparam bit DED = (P == port_mode_pkg::DED_IN_PORT) &&
                                 (B == port_mode_pkg::DED_IN_BIT);
            localparam bit I2C = (P == 1) &&
                                 (B == port_mode_pkg::SDA_BIT ||
                                  B == port_mode_pkg::SCL_BIT);
            // Serial-bus pins drive although their mode bits are absent
            localparam bit NONE = !MASK[P][B] && !I2C;
            port_mode_pkg::pin_mode_t mode;
            logic l;

            // RL15 RL16 RL10 decode, reset-zero bits give quasi
            always_comb
            begin
                if (I2C)
                begin
                    mode = port_mode_pkg::MODE_OPEN_DRAIN;
                end
                else
                begin
                    mode = port_mode_pkg::pin_mode_t'(
                        {mode_a_q[P][B], mode_b_q[P][B]});
                end
            end
            assign l = latch_o[gb];

            // RL3 two-clock strong pull-up on latch rise
            always_ff @(posedge clk_i)
            begin
                if (sys_rst_i)
                begin
                    spu_cnt_q[gb] <= 2'h0;
                end
                else if (mode == port_mode_pkg::MODE_QUASI && l
                         && !prev_latch_q[gb])
                begin
                    spu_cnt_q[gb] <= 2'(STRONG_CLKS);
                end
                else if (spu_cnt_q[gb] != 2'h0)
                begin
                    spu_cnt_q[gb] <= spu_cnt_q[gb] - 2'h1;
                end
            end

            always_comb
            begin
                drive_o[gb] = '0;
                // RL11 RL12 threshold select
                drive_o[gb].schmitt = DED ? 1'b1 : thresh_q[P];
                // RL8 dedicated or absent pin: no drivers
                if (!DED && !NONE)
                begin
                    case (mode)
                        port_mode_pkg::MODE_QUASI:
                        begin
                            // RL1 RL2 RL4 quasi drivers
                            drive_o[gb].very_weak_pu = l;
                            drive_o[gb].weak_pu = l && pin_level_i[gb];
                            drive_o[gb].strong_pu = l &&
                                (spu_cnt_q[gb] != 2'h0);
                            drive_o[gb].pull_down = !l;
                        end
                        port_mode_pkg::MODE_PUSH_PULL:
                        begin
                            // RL6 continuous strong pull-up
                            drive_o[gb].strong_pu = l;
                            drive_o[gb].pull_down = !l;
                        end
                        port_mode_pkg::MODE_OPEN_DRAIN:
                        begin
                            // RL5 pull-down only
                            drive_o[gb].pull_down = !l;
                        end
                        port_mode_pkg::MODE_INPUT_ONLY:
                        begin
                            // RL7 no drivers
                            drive_o[gb].pull_down = 1'b0;
                        end
                        default:
                        begin
                            drive_o[gb].pull_down = 1'b0;
                        end
                    endcase
                end
            end

            // RL4 quasi-mode latch zero pulls low on every pin except dedicated and absent ones
            property p_low;
                @(posedge clk_i) disable iff (sys_rst_i)
                (mode == port_mode_pkg::MODE_QUASI && !DED && !NONE && !l)
                |-> drive_o[gb].pull_down;
            endproperty
            a_low: assert property (p_low) // RL4
                else $error("quasi pin not pulled low");
        end
    endgenerate

    // RL3 strong pull-up lasts two cycles
    sequence s_rise;
        g_pin[0].mode == port_mode_pkg::MODE_QUASI && $rose(latch_o[0]);
    endsequence
    sequence s_held;
        g_pin[0].mode == port_mode_pkg::MODE_QUASI && latch_o[0];
    endsequence
    // Counter loads at the edge that sees the rise, so drive lags one cycle
    property p_strong;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_rise ##1 s_held ##1 s_held ##1 s_held |->
            !drive_o[0].strong_pu && $past(drive_o[0].strong_pu)
            && $past(drive_o[0].strong_pu, 2);
    endproperty
    a_strong: assert property (p_strong) // RL3
        else $error("strong pulse length");

    // RL16 serial pins: no strong pull-up on pin 13, no very weak pull-up on pin 14
    property p_i2c;
        @(posedge clk_i) disable iff (sys_rst_i)
        !drive_o[13].strong_pu && !drive_o[14].very_weak_pu;
    endproperty
    a_i2c: assert property (p_i2c) // RL16
        else $error("serial pin pulled up");

    // RL12 dedicated pin Schmitt, no drive
    property p_ded;
        @(posedge clk_i) disable iff (sys_rst_i)
        drive_o[12].schmitt && !drive_o[12].pull_down;
    endproperty
    a_ded: assert property (p_ded) else $error("dedicated pin wrong"); // RL12

    // RL17 masked bits read zero
    property p_mask;
        @(posedge clk_i) disable iff (sys_rst_i)
        (mode_a_q[1] & ~port_mode_pkg::MASK_PORT1) == 8'h00 &&
        (mode_b_q[4] & ~port_mode_pkg::MASK_PORT4) == 8'h00;
    endproperty
    a_mask: assert property (p_mask) // RL17
        else $error("unimplemented bit set");

    // RL2 weak pull-up follows pin
    property p_weak;
        @(posedge clk_i) disable iff (sys_rst_i)
        (g_pin[0].mode == port_mode_pkg::MODE_QUASI && latch_o[0]
         && !pin_level_i[0])
        |-> !drive_o[0].weak_pu && drive_o[0].very_weak_pu;
    endproperty
    a_weak: assert property (p_weak) // RL2
        else $error("weak pull-up on low pin");

    // RL18 write reaches driver next cycle
    property p_wr;
        @(posedge clk_i) disable iff (sys_rst_i)
        (wr_en && wr_idx == port_mode_pkg::IDX_P0_MODE_A)
        |=> mode_a_q[0] == $past(wbyte);
    endproperty
    a_wr: assert property (p_wr) else $error("mode write lost"); // RL18

    // RL6 push-pull strong high
    property p_pp;
        @(posedge clk_i) disable iff (sys_rst_i)
        (g_pin[1].mode == port_mode_pkg::MODE_PUSH_PULL && latch_o[1])
        |-> drive_o[1].strong_pu;
    endproperty
    a_pp: assert property (p_pp) else $error("push-pull not driving"); // RL6

    // RL10 quasi after reset
    property p_rst;
        @(posedge clk_i) $fell(sys_rst_i) |-> mode_a_q[2] == 8'h00
            && mode_b_q[2] == 8'h00;
    endproperty
    a_rst: assert property (p_rst) // RL10
        else $error("reset mode not quasi");

endmodule

`default_nettype wire

// [tb/pin_load_model.sv]
/*
 * Loads on the port pins: turns driver enables into a pin level.
 * Assumes an external device may sink any pin; no external pull-ups.
 */
`timescale 1ns/1ns
`default_nettype none

module pin_load_model (
    input  wire logic                      clk_i,
    input  wire port_mode_pkg::pin_drive_t drive_i [40],
    input  wire logic [39:0]               sink_i,
    output logic      [39:0]               pin_level_o
);
    // Undriven pins wander, never settle
    logic float_q = 1'h0;

    always @(posedge clk_i)
        float_q <= ~float_q;

    always_comb
    begin
        for (int i = 0; i < 40; i++)
        begin
            if (drive_i[i].pull_down)
                pin_level_o[i] = 1'h0;
            else if (drive_i[i].strong_pu)
                pin_level_o[i] = 1'h1;
            else if (sink_i[i])
                pin_level_o[i] = 1'h0;
            else if (drive_i[i].weak_pu | drive_i[i].very_weak_pu)
                pin_level_o[i] = 1'h1;
            else
                pin_level_o[i] = float_q;
        end
    end
endmodule

`default_nettype wire

// [tb/port_pin_mode_control_tb.sv]
/*
 * Bench for the port pin mode control block over AXI4-Lite.
 * Assumes the pin load model closes the loop from drive to level.
 */
`timescale 1ns/1ns
`default_nettype none

module port_pin_mode_control_tb;
    localparam logic [4:0] E1 [4] = '{5'h18, 5'h04, 5'h00, 5'h00};
    localparam logic [4:0] E0 [4] = '{5'h02, 5'h02, 5'h00, 5'h02};
    localparam logic [7:0] RI [11] = '{8'h9E, 8'hB1, 8'hB2, 8'hB3,
        8'hB4, 8'hB5, 8'hB6, 8'hEC, 8'hFA, 8'hFB, 8'hC0};
    localparam logic [7:0] MI [3] = '{8'hB3, 8'hFB, 8'hEC};
    localparam logic [7:0] MM [3] = '{8'h8F, 8'h0F, 8'h1F};

    logic        clk_i = 1'h0;
    logic        rst = 1'h1;
    logic        lvl = 1'h1;
    logic [39:0] latch = '1;
    logic [39:0] sink = '0;
    logic [39:0] pin;
    logic [39:0] latch_o;
    port_mode_pkg::pin_drive_t drv [40];
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic        awvalid = 1'h0;
    logic        wvalid = 1'h0;
    logic        arvalid = 1'h0;
    logic        bready = 1'h0;
    logic        rready = 1'h0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    int          failures = 0;
    int          n_compared = 0;

    always #25 clk_i = ~clk_i;

    port_pin_mode_control dut (
        .clk_i(clk_i), .sys_rst_i(rst), .reset_level_select_i(lvl),
        .latch_i(latch), .pin_level_i(pin), .latch_o(latch_o),
        .drive_o(drv), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );

    pin_load_model load (
        .clk_i(clk_i), .drive_i(drv), .sink_i(sink), .pin_level_o(pin)
    );

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic ck_pin(input int i, input logic [4:0] e);
        repeat (2) @(negedge clk_i);
        check(40'(drv[i]), 40'(e));
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic aw_hit;
        logic w_hit;
        @(posedge clk_i);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        // Both halves may be taken on different edges
        do
        begin
            @(negedge clk_i);
            aw_hit = awvalid & awready;
            w_hit = wvalid & wready;
            @(posedge clk_i);
            if (aw_hit)
                awvalid <= 1'h0;
            if (w_hit)
                wvalid <= 1'h0;
        end
        while ((awvalid & !aw_hit) | (wvalid & !w_hit));
        do
            @(negedge clk_i);
        while (bvalid !== 1'h1);
        check(40'(bresp), 40'h0);
        @(posedge clk_i);
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk_i);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
            @(negedge clk_i);
        while (arready !== 1'h1);
        @(posedge clk_i);
        arvalid <= 1'h0;
        do
            @(negedge clk_i);
        while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        @(posedge clk_i);
        rready <= 1'h0;
    endtask

    task automatic t_reset(input logic l);
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge clk_i);
        rst <= 1'h1;
        lvl <= l;
        latch <= {40{l}};
        repeat (8) @(posedge clk_i);
        rst <= 1'h0;
        @(negedge clk_i);
        check(latch_o, {40{l}});
        ck_pin(0, l ? 5'h18 : 5'h02);
        for (int i = 0; i < 11; i++)
        begin
            rd(RI[i], d, r);
            check(40'({r, d}), 40'h0);
        end
        rd(8'h10, d, r);
        check(40'({r, d}), 40'h2_0000_0000);
        $display("reset test done");
    endtask

    task automatic t_quasi;
        int cnt;
        cnt = 0;
        @(posedge clk_i);
        latch[0] <= 1'h0;
        ck_pin(0, 5'h02);
        @(posedge clk_i);
        latch[0] <= 1'h1;
        repeat (8)
        begin
            @(negedge clk_i);
            if (drv[0].strong_pu === 1'h1)
                cnt++;
        end
        check(40'(cnt), 40'h2);
        ck_pin(0, 5'h18);
        @(posedge clk_i);
        sink[0] <= 1'h1;
        ck_pin(0, 5'h10);
        @(posedge clk_i);
        sink[0] <= 1'h0;
        $display("quasi test done");
    endtask

    task automatic t_special;
        ck_pin(12, 5'h01);
        ck_pin(13, 5'h00);
        wr(8'hEC, 32'h01);
        ck_pin(0, 5'h19);
        ck_pin(8, 5'h18);
        wr(8'hEC, 32'h02);
        ck_pin(8, 5'h19);
        ck_pin(0, 5'h18);
        @(posedge clk_i);
        latch[13] <= 1'h0;
        ck_pin(13, 5'h03);
        wr(8'hEC, 32'h00);
        ck_pin(12, 5'h01);
        $display("special pins test done");
    endtask

    task automatic t_masks;
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 3; i++)
        begin
            wr(MI[i], 32'hFFFF_FFFF);
            rd(MI[i], d, r);
            check(40'(d), 40'(MM[i]));
            wr(MI[i], 32'h0);
        end
        $display("mask test done");
    endtask

    task automatic t_modes;
        for (int m = 0; m < 4; m++)
        begin
            wr(8'hB1, 32'(m[1]));
            wr(8'hB2, 32'(m[0]));
            ck_pin(0, E1[m]);
            @(posedge clk_i);
            latch[0] <= 1'h0;
            ck_pin(0, E0[m]);
            @(posedge clk_i);
            latch[0] <= 1'h1;
            repeat (4) @(posedge clk_i);
        end
        $display("mode test done");
    endtask

    task automatic summarize;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        t_reset(1'h1);
        t_quasi;
        t_special;
        t_masks;
        t_modes;
        t_reset(1'h0);
        summarize;
    end

    // Whole run needs well under 3000 cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        failures++;
        summarize;
    end
endmodule

`default_nettype wire
